//--- design/i2cm_top.sv
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// [R1] Busy flag high while a byte moves on the bus, low once finished.
// [R2] Ten commands: single write/read, burst first/next/last/abort both ways.
// [R3] Data register read returns last received byte, zero extended.
// [R4] Data register write holds the byte the next send transmits.
// [R5] Enable control; disabled master leaves the bus alone.
// [R6] Error status: none, address nack, data nack, arbitration lost.
// [R7] Fast select gives 400 kbps serial clock, else 100 kbps.
// [R8] Software init sets speed and enable; both live in control register.
// [R9] Bus clock divider derives from the module clock rate.
// [R10] Clearing the pending interrupt stops the interrupt output.
// [R11] Software should clear the interrupt early in its handler.
// [R12] Mask bit gates the pending interrupt onto the interrupt line.
// [R13] Raw and masked interrupt states both readable.
// [R14] Interrupt pends when the master leaves busy, done or aborted.
// [R15] Start commands arbitrate, make start, send address and direction.
// [R16] 7-bit slave address plus receive flag choosing direction bit.
// [R17] Shared bus occupancy flag from start and stop detection.
// [R18] Single, finish and abort end with stop; last read byte nacked.
module i2cm_top import i2cm_pkg::*; #(
	parameter int CLK_HZ = CLK_HZ_DEF
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	output logic irq_o,
	output logic busy_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o
);
	// Quarter-bit counts round up so the bus never runs above its rate
	localparam int Q_STD_N = (CLK_HZ + QUARTERS * SCL_STD_HZ - 1) / (QUARTERS * SCL_STD_HZ);
	localparam int Q_FAST_N = (CLK_HZ + QUARTERS * SCL_FAST_HZ - 1) / (QUARTERS * SCL_FAST_HZ);
	localparam logic [DIV_W-1:0] Q_STD = DIV_W'(Q_STD_N - 1); // [R9]
	localparam logic [DIV_W-1:0] Q_FAST = DIV_W'(Q_FAST_N - 1); // [R9]

	logic scl_m_q, scl_s_q, sda_m_q, sda_s_q, sda_p_q;
	logic [7:0] tx_q, tx_d, rx_q, rx_d;
	logic [6:0] sadr_q, sadr_d;
	logic rcv_q, rcv_d, en_q, en_d, fast_rate_select_q, fast_rate_select_d;
	logic masked_view_select_q, masked_view_select_d;
	logic raw_q, raw_d, mask_q, mask_d, irq_q, irq_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	i2cm_state_t state_q, state_d;
	logic [1:0] phase_q, phase_d, err_q, err_d;
	logic [3:0] bit_q, bit_d;
	logic [8:0] sh_q, sh_d;
	logic [DIV_W-1:0] div_q, div_d, div_max;
	logic addr_ph_q, addr_ph_d, rx_ph_q, rx_ph_d, stop_q, stop_d, own_q, own_d;
	logic busy_q, busy_d, bus_busy_q, bus_busy_d;
	logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
	logic start_seen, stop_seen, tick, stall, cmd_go, c_start, c_data, c_stop, done;

	// Pin synchronisers; logic reads the second stage, and the third data stage for edge detection
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= scl_i;
			scl_s_q <= scl_m_q;
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	// Bus conditions seen on the wire, ours or another master's
	assign start_seen = scl_s_q && sda_p_q && !sda_s_q;
	assign stop_seen = scl_s_q && !sda_p_q && sda_s_q;
	assign done = (state_q == ST_DONE);
	assign cmd_go = reg_wr_i && (reg_addr_i == OFS_CMD) && en_q && (state_q == ST_IDLE);

	// Command decode: which phases the command runs
	always_comb begin
		c_start = 1'b0;
		c_data = 1'b0;
		c_stop = 1'b0;
		case (reg_wdata_i[3:0]) // [R2]
			cmd_single_write, cmd_single_read: begin
				c_start = 1'b1;
				c_data = 1'b1;
				c_stop = 1'b1; // [R18]
			end
			cmd_multi_write_first, cmd_multi_read_first: begin
				c_start = 1'b1;
				c_data = 1'b1;
			end
			cmd_multi_write_next, cmd_multi_read_next: c_data = 1'b1;
			cmd_multi_write_last, cmd_multi_read_last: begin
				c_data = 1'b1;
				c_stop = 1'b1; // [R18]
			end
			cmd_multi_write_abort, cmd_multi_read_abort: c_stop = 1'b1; // [R18]
			default: c_stop = 1'b0; // Unknown codes start nothing but still clear the error status
		endcase
	end

	// Quarter-bit divider; stalls while a slave stretches the clock
	assign div_max = fast_rate_select_q ? Q_FAST : Q_STD; // [R7]
	assign stall = (state_q != ST_IDLE) && (phase_q == 2'd2) && !scl_s_q;
	assign tick = (div_q == div_max) && !stall;

	// Bit engine next state
	always_comb begin
		state_d = state_q;
		phase_d = phase_q;
		bit_d = bit_q;
		sh_d = sh_q;
		err_d = err_q;
		rx_d = rx_q;
		addr_ph_d = addr_ph_q;
		rx_ph_d = rx_ph_q;
		stop_d = stop_q;
		own_d = own_q;
		scl_oe_d = scl_oe_q;
		sda_oe_d = sda_oe_q;
		bus_busy_d = start_seen ? 1'b1 : (stop_seen ? 1'b0 : bus_busy_q); // [R17]
		div_d = (state_q == ST_IDLE || tick) ? '0 : (stall ? div_q : div_q + 1'b1);
		if (!en_q) begin
			// Disabled: drop everything and release both lines
			state_d = ST_IDLE; // [R5]
			scl_oe_d = 1'b0;
			sda_oe_d = 1'b0;
			own_d = 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: if (cmd_go) begin
					err_d = err_code_none; // [R6]
					phase_d = 2'd0;
					bit_d = 4'h0;
					stop_d = c_stop;
					if (c_start && bus_busy_q && !own_q) begin
						err_d = err_code_arbitration_lost; // [R15]
						state_d = ST_DONE;
					end else if (c_start) begin
						sh_d = {sadr_q, rcv_q, 1'b1}; // [R16]
						addr_ph_d = 1'b1;
						rx_ph_d = 1'b0;
						state_d = ST_START; // [R15]
					end else if (c_data) begin
						sh_d = rcv_q ? {8'hff, c_stop} : {tx_q, 1'b1}; // [R4]
						addr_ph_d = 1'b0;
						rx_ph_d = rcv_q;
						state_d = ST_BITS;
					end else if (c_stop) begin
						state_d = ST_STOP;
					end
				end
				ST_START: if (tick) begin
					phase_d = phase_q + 2'd1;
					unique case (phase_q)
						2'd0: sda_oe_d = 1'b0;
						2'd1: scl_oe_d = 1'b0;
						2'd2: if (!sda_s_q) begin
							// Someone else holds data low: we lost the bus
							err_d = err_code_arbitration_lost; // [R6]
							state_d = ST_DONE;
						end else begin
							sda_oe_d = 1'b1; // [R15]
							own_d = 1'b1;
						end
						2'd3: begin
							scl_oe_d = 1'b1;
							state_d = ST_BITS;
						end
					endcase
				end
				ST_BITS: if (tick) begin
					phase_d = phase_q + 2'd1;
					unique case (phase_q)
						2'd0: sda_oe_d = !sh_q[8];
						2'd1: scl_oe_d = 1'b0;
						2'd2: begin
							sh_d = {sh_q[7:0], sda_s_q};
							if (!sda_oe_q && !sda_s_q && bit_q != BIT_ACK && !rx_ph_q) begin
								err_d = err_code_arbitration_lost; // [R6]
								scl_oe_d = 1'b0;
								own_d = 1'b0;
								state_d = ST_DONE;
							end
						end
						2'd3: begin
							scl_oe_d = 1'b1;
							bit_d = bit_q + 4'h1;
							if (bit_q == BIT_ACK) begin
								bit_d = 4'h0;
								if (addr_ph_q) begin
									addr_ph_d = 1'b0;
									rx_ph_d = rcv_q;
									// Last read byte answered with nack
									sh_d = rcv_q ? {8'hff, stop_q} : {tx_q, 1'b1}; // [R18]
									if (sh_q[0]) begin
										err_d = err_code_addr_nack; // [R6]
										state_d = ST_STOP;
									end
								end else begin
									if (rx_ph_q) begin
										rx_d = sh_q[8:1]; // [R3]
									end
									if (!rx_ph_q && sh_q[0]) begin
										err_d = err_code_data_nack; // [R6]
										state_d = ST_STOP;
									end else begin
										state_d = stop_q ? ST_STOP : ST_DONE; // [R18]
									end
								end
							end
						end
					endcase
				end
				ST_STOP: if (tick) begin
					phase_d = phase_q + 2'd1;
					unique case (phase_q)
						2'd0: sda_oe_d = 1'b1;
						2'd1: scl_oe_d = 1'b0;
						2'd2: begin
							sda_oe_d = 1'b0; // [R18]
							own_d = 1'b0;
						end
						2'd3: state_d = ST_DONE;
					endcase
				end
				ST_DONE: state_d = ST_IDLE; // [R14]
			endcase
		end
		busy_d = (state_d != ST_IDLE); // [R1]
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
			phase_q <= 2'd0;
			bit_q <= 4'h0;
			sh_q <= 9'h1ff;
			err_q <= err_code_none;
			rx_q <= BYTE_RST;
			addr_ph_q <= 1'b0;
			rx_ph_q <= 1'b0;
			stop_q <= 1'b0;
			own_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			bus_busy_q <= 1'b0;
			div_q <= '0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			phase_q <= phase_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			err_q <= err_d;
			rx_q <= rx_d;
			addr_ph_q <= addr_ph_d;
			rx_ph_q <= rx_ph_d;
			stop_q <= stop_d;
			own_q <= own_d;
			scl_oe_q <= scl_oe_d;
			sda_oe_q <= sda_oe_d;
			bus_busy_q <= bus_busy_d;
			div_q <= div_d;
			busy_q <= busy_d;
		end
	end

	// Register file; reads answer one cycle later, unmapped reads give zero
	always_comb begin
		tx_d = tx_q;
		sadr_d = sadr_q;
		rcv_d = rcv_q;
		en_d = en_q;
		fast_rate_select_d = fast_rate_select_q;
		masked_view_select_d = masked_view_select_q;
		mask_d = mask_q;
		raw_d = raw_q;
		rdata_d = '0;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				OFS_DATA: tx_d = reg_wdata_i[7:0]; // [R4]
				OFS_SLAVE: begin
					sadr_d = reg_wdata_i[SLAVE_ADR_LSB +: 7]; // [R16]
					rcv_d = reg_wdata_i[SLAVE_RCV_BIT];
				end
				OFS_CTRL: begin
					en_d = reg_wdata_i[CTRL_EN_BIT]; // [R5] [R8]
					fast_rate_select_d = reg_wdata_i[CTRL_FAST_BIT]; // [R7] [R8]
					masked_view_select_d = reg_wdata_i[CTRL_VIEW_BIT];
				end
				OFS_INT: if (reg_wdata_i[INT_RAW_BIT]) raw_d = 1'b0; // [R10]
				OFS_MASK: mask_d = reg_wdata_i[0]; // [R12]
				default: ;
			endcase
		end
		// A completion in the clearing cycle must not be lost
		if (done) raw_d = 1'b1; // [R14]
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				OFS_DATA: rdata_d = {24'h0, rx_q}; // [R3]
				OFS_SLAVE: rdata_d = {24'h0, sadr_q, rcv_q};
				OFS_CTRL: rdata_d = {29'h0, masked_view_select_q, fast_rate_select_q, en_q};
				OFS_CMD: rdata_d = {28'h0, err_q, bus_busy_q, busy_q}; // [R1] [R6] [R17]
				OFS_INT: rdata_d = {29'h0, raw_q && mask_q, raw_q,
					masked_view_select_q ? (raw_q && mask_q) : raw_q}; // [R13]
				OFS_MASK: rdata_d = {31'h0, mask_q};
				default: rdata_d = '0;
			endcase
		end
		irq_d = raw_q && mask_q; // [R12]
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_q <= BYTE_RST;
			sadr_q <= 7'h00;
			rcv_q <= 1'b0;
			{masked_view_select_q, fast_rate_select_q, en_q} <= CTRL_RST;
			mask_q <= 1'b0;
			raw_q <= 1'b0;
			irq_q <= 1'b0;
			rdata_q <= '0;
		end else begin
			tx_q <= tx_d;
			sadr_q <= sadr_d;
			rcv_q <= rcv_d;
			en_q <= en_d;
			fast_rate_select_q <= fast_rate_select_d;
			masked_view_select_q <= masked_view_select_d;
			mask_q <= mask_d;
			raw_q <= raw_d;
			irq_q <= irq_d;
			rdata_q <= rdata_d;
		end
	end

	// Open-drain pins: output level is always low, enable pulls the wire
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end
	end
	assign scl_oe_o = scl_oe_q;
	assign sda_oe_o = sda_oe_q;
	assign busy_o = busy_q;
	assign irq_o = irq_q;
	assign reg_rdata_o = rdata_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// Unknown codes are accepted but start nothing, so they stay out of this check
	chk_cmd_busy: assert property (cmd_go && (c_start || c_data || c_stop) |=> busy_o) // [R1]
		else $error("busy not raised after command");
	chk_done_idle: assert property (done |=> !busy_o) // [R1]
		else $error("busy still high after completion");
	chk_abort_stop: assert property (cmd_go && reg_wdata_i[3:0] == cmd_multi_write_abort
		|=> state_q == ST_STOP) // [R2]
		else $error("abort did not go to stop");
	chk_data_read: assert property (reg_rd_i && reg_addr_i == OFS_DATA
		|=> reg_rdata_o == {24'h0, $past(rx_q)}) // [R3]
		else $error("data read mismatch");
	chk_data_write: assert property (reg_wr_i && reg_addr_i == OFS_DATA
		|=> tx_q == $past(reg_wdata_i[7:0])) // [R4]
		else $error("data write not held");
	chk_disabled_quiet: assert property (!en_q |=> !scl_oe_o && !sda_oe_o && !busy_o) // [R5]
		else $error("disabled master touched bus");
	chk_addr_nack: assert property (state_q == ST_BITS && addr_ph_q && bit_q == BIT_ACK
		&& phase_q == 2'd3 && tick && sh_q[0] |=> err_q == err_code_addr_nack) // [R6]
		else $error("address nack not reported");
	chk_fast_rate: assert property (tick && fast_rate_select_q |-> div_q == Q_FAST) // [R7]
		else $error("fast quarter count wrong");
	chk_int_clear: assert property (reg_wr_i && reg_addr_i == OFS_INT
		&& reg_wdata_i[INT_RAW_BIT] && !done |=> !raw_q ##1 !irq_o) // [R10]
		else $error("interrupt clear failed");
	chk_irq_gate: assert property (!mask_q |=> !irq_o) // [R12]
		else $error("masked interrupt reached output");
	chk_masked_view: assert property (reg_rd_i && reg_addr_i == OFS_INT
		|=> reg_rdata_o[INT_MSK_BIT] == ($past(raw_q) && $past(mask_q))) // [R13]
		else $error("masked status wrong");
	chk_raw_set: assert property (done |=> raw_q) // [R14]
		else $error("completion did not pend");
	chk_start_cond: assert property (state_q == ST_START && phase_q == 2'd2 && tick
		&& sda_s_q |=> sda_oe_o && !scl_oe_o) // [R15]
		else $error("start condition malformed");
	chk_bus_seen: assert property (start_seen |=> bus_busy_q) // [R17]
		else $error("bus busy not flagged");
	chk_stop_cond: assert property (state_q == ST_STOP && phase_q == 2'd2 && tick
		|=> !sda_oe_o && !scl_oe_o) // [R18]
		else $error("stop condition malformed");
endmodule : i2cm_top

//--- design/i2cm_pkg.sv
package i2cm_pkg;
	// Register port shape
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFS_DATA = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SLAVE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CMD = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_INT = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h14;
	// Field positions
	localparam int SLAVE_RCV_BIT = 0;
	localparam int SLAVE_ADR_LSB = 1;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_FAST_BIT = 1;
	localparam int CTRL_VIEW_BIT = 2;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_BUS_BIT = 1;
	localparam int STAT_ERR_LSB = 2;
	localparam int INT_VIEW_BIT = 0;
	localparam int INT_RAW_BIT = 1;
	localparam int INT_MSK_BIT = 2;
	// Reset values
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [7:0] BYTE_RST = 8'h00;
	// Command codes
	localparam logic [3:0] cmd_single_write = 4'h0;
	localparam logic [3:0] cmd_single_read = 4'h1;
	localparam logic [3:0] cmd_multi_write_first = 4'h2;
	localparam logic [3:0] cmd_multi_write_next = 4'h3;
	localparam logic [3:0] cmd_multi_write_last = 4'h4;
	localparam logic [3:0] cmd_multi_write_abort = 4'h5;
	localparam logic [3:0] cmd_multi_read_first = 4'h6;
	localparam logic [3:0] cmd_multi_read_next = 4'h7;
	localparam logic [3:0] cmd_multi_read_last = 4'h8;
	localparam logic [3:0] cmd_multi_read_abort = 4'h9;
	// Error codes
	localparam logic [1:0] err_code_none = 2'h0;
	localparam logic [1:0] err_code_addr_nack = 2'h1;
	localparam logic [1:0] err_code_data_nack = 2'h2;
	localparam logic [1:0] err_code_arbitration_lost = 2'h3;
	// Timing
	localparam int CLK_HZ_DEF = 250_000_000;
	localparam int SCL_STD_HZ = 100_000;
	localparam int SCL_FAST_HZ = 400_000;
	localparam int QUARTERS = 4;
	localparam int DIV_W = 12;
	localparam logic [3:0] BIT_ACK = 4'h8;
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BITS, ST_STOP, ST_DONE} i2cm_state_t;
endpackage : i2cm_pkg

//--- bench/i2cm_slave_model.sv
`timescale 1ns/1ps
// Behavioural bus target; it only pulls lines low, the pull-ups do the rest
module i2cm_slave_model #(
	parameter logic [6:0] ADDR = 7'h2a,
	parameter logic [7:0] RD0 = 8'h5a
) (
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic nack_data_i,
	input wire logic stretch_i,
	output logic scl_oe_o,
	output logic sda_oe_o,
	output logic [7:0] last_wr_o
);
	logic act = 1'b0;
	logic first, rd, go;
	logic [3:0] cnt;
	logic [7:0] sh, tx;
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
		last_wr_o = 8'h00;
	end
	// Start and stop are data edges while the clock line is high
	always @(negedge sda_i) if (scl_i) begin
		act = 1'b1;
		first = 1'b1;
		go = 1'b0;
		cnt = 4'h0;
	end
	always @(posedge sda_i) if (scl_i) begin
		act = 1'b0;
		sda_oe_o = 1'b0;
	end
	// Sample on the rising clock; the ninth bit carries the acknowledge
	always @(posedge scl_i) if (act) begin
		if (cnt < 4'h8) sh = {sh[6:0], sda_i};
		else begin
			// Step gives the byte after RD0 a set top bit, so a stop after the first data ack is not blocked
			if (!first && rd) tx = tx + 8'h91;
			go = first ? 1'b1 : !sda_i; // Master nack ends a read
			first = 1'b0;
		end
		cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
	end
	// Drive only while the clock is low so no false start or stop appears
	always @(negedge scl_i) if (act) begin
		if (cnt == 4'h8 && first) begin
			rd = sh[0];
			tx = RD0;
			act = (sh[7:1] == ADDR);
			sda_oe_o = act;
		end else if (cnt == 4'h8) begin
			if (!rd) last_wr_o = sh;
			sda_oe_o = !rd && !nack_data_i;
		end else sda_oe_o = go && rd && !tx[7 - cnt];
	end
	// Optional stretch after each falling clock, to make the master wait
	always @(negedge scl_i) if (stretch_i && act) begin
		scl_oe_o = 1'b1;
		#200 scl_oe_o = 1'b0;
	end
endmodule : i2cm_slave_model

//--- bench/tb_i2cm_top.sv
`timescale 1ns/1ps
module tb_i2cm_top;
	import i2cm_pkg::*;
	localparam int CLKHZ = 4_000_000;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [ADDR_W-1:0] reg_addr_i = '0;
	logic [DATA_W-1:0] reg_wdata_i = '0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [DATA_W-1:0] reg_rdata_o;
	logic irq_o, busy_o, scl_o, scl_oe_o, sda_o, sda_oe_o, s_scl_oe, s_sda_oe;
	logic nack_data = 1'b0;
	logic stretch = 1'b0;
	logic other_oe = 1'b0;
	logic [7:0] last_wr;
	logic [3:0] wcmd [5] = '{4'h2, 4'h3, 4'h4, 4'h2, 4'h5};
	logic [7:0] wexp [5] = '{8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'hd4};
	logic [3:0] rcmd [5] = '{4'h6, 4'h7, 4'h8, 4'h6, 4'h9};
	logic [7:0] rexp [5] = '{8'h5a, 8'heb, 8'h7c, 8'h5a, 8'h5a};
	logic [3:0] rstat [5] = '{4'h2, 4'h2, 4'h0, 4'h2, 4'h0};
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	// Open-drain wires with pull-ups; a third party can hold data low
	wire scl_w = !(scl_oe_o || s_scl_oe);
	wire sda_w = !(sda_oe_o || s_sda_oe || other_oe);
	always #2 clk_i = ~clk_i;
	i2cm_top #(.CLK_HZ(CLKHZ)) i2cm_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .busy_o(busy_o),
		.scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o));
	i2cm_slave_model i2cm_slave_model_inst (.scl_i(scl_w), .sda_i(sda_w),
		.nack_data_i(nack_data), .stretch_i(stretch), .scl_oe_o(s_scl_oe),
		.sda_oe_o(s_sda_oe), .last_wr_o(last_wr));
	task automatic summarize;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	// Read data is looked at only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_i);
		chk(reg_rdata_o, exp);
	endtask : rd
	// Issue a command and wait out the transfer; the timeout catches a hang
	task automatic go(input logic [3:0] c);
		wr(OFS_CMD, {28'h0, c});
		@(negedge clk_i);
		chk(busy_o, 1'b1);
		while (busy_o === 1'b1) @(negedge clk_i);
		repeat (4) @(negedge clk_i);
	endtask : go
	function automatic int qof(input int hz);
		return (CLKHZ + 4 * hz - 1) / (4 * hz);
	endfunction : qof
	// Period between two data-bit clock rises; synchroniser slack allowed
	task automatic meas(input int q);
		time p;
		@(posedge scl_w);
		@(posedge scl_w);
		p = $time;
		@(posedge scl_w);
		p = ($time - p) / 4;
		chk(p >= 4 * q && p <= 4 * q + 3, 1);
	endtask : meas
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 80000) begin
			errors++;
			$display("Error at %0t: timeout", $time);
			summarize();
		end
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(OFS_CTRL, 0);
		rd(OFS_MASK, 0);
		rd(OFS_INT, 0);
		rd(OFS_CMD, 0);
		rd(8'h1c, 0);
		wr(OFS_SLAVE, 32'h54);
		wr(OFS_DATA, 32'ha5);
		wr(OFS_CMD, 32'h0);
		@(negedge clk_i);
		chk(busy_o, 0);
		$display("done: reset and disabled");
		wr(OFS_CTRL, 32'h1);
		// A code outside the ten commands is taken but starts nothing
		wr(OFS_CMD, 32'ha);
		@(negedge clk_i);
		chk(busy_o, 0);
		fork
			go(cmd_single_write);
			meas(qof(SCL_STD_HZ));
		join
		chk(last_wr, 8'ha5);
		rd(OFS_CMD, 0);
		rd(OFS_INT, 32'h3);
		chk(irq_o, 0);
		wr(OFS_INT, 32'h2);
		rd(OFS_INT, 0);
		wr(OFS_MASK, 32'h1);
		wr(OFS_SLAVE, 32'h55);
		go(cmd_single_read);
		chk(irq_o, 1);
		rd(OFS_INT, 32'h7);
		rd(OFS_DATA, 32'h5a);
		wr(OFS_CTRL, 32'h5);
		wr(OFS_MASK, 32'h0);
		rd(OFS_INT, 32'h2);
		wr(OFS_MASK, 32'h1);
		wr(OFS_INT, 32'h2);
		@(posedge clk_i);
		@(negedge clk_i);
		chk(irq_o, 0);
		$display("done: single transfers and interrupt");
		wr(OFS_SLAVE, 32'h22);
		go(cmd_single_write);
		rd(OFS_CMD, 32'h4);
		wr(OFS_SLAVE, 32'h54);
		nack_data <= 1'b1;
		go(cmd_single_write);
		rd(OFS_CMD, 32'h8);
		nack_data <= 1'b0;
		$display("done: refusals");
		// Bursts: first, next, last and abort, both ways
		for (int i = 0; i < 5; i++) begin
			wr(OFS_DATA, {24'h0, wexp[i] + 8'h11 * (i == 4)});
			go(wcmd[i]);
			chk(last_wr, wexp[i]);
		end
		wr(OFS_SLAVE, 32'h55);
		for (int i = 0; i < 5; i++) begin
			go(rcmd[i]);
			rd(OFS_DATA, rexp[i]);
			rd(OFS_CMD, rstat[i]);
		end
		$display("done: bursts");
		// Another party starts a transfer: bus busy, then arbitration lost
		other_oe <= 1'b1;
		repeat (4) @(posedge clk_i);
		rd(OFS_CMD, 32'h2);
		go(cmd_single_write);
		rd(OFS_CMD, 32'he);
		other_oe <= 1'b0;
		repeat (4) @(posedge clk_i);
		rd(OFS_CMD, 32'hc);
		$display("done: arbitration");
		wr(OFS_SLAVE, 32'h54);
		wr(OFS_CTRL, 32'h3);
		wr(OFS_DATA, 32'he5);
		fork
			go(cmd_single_write);
			meas(qof(SCL_FAST_HZ));
		join
		chk(last_wr, 8'he5);
		stretch <= 1'b1;
		wr(OFS_DATA, 32'h96);
		go(cmd_single_write);
		chk(last_wr, 8'h96);
		stretch <= 1'b0;
		$display("done: fast and stretch");
		wr(OFS_CTRL, 32'h1);
		wr(OFS_CMD, 32'h0);
		repeat (60) @(posedge clk_i);
		wr(OFS_CTRL, 32'h0);
		repeat (3) @(negedge clk_i);
		chk({busy_o, scl_oe_o, sda_oe_o, scl_o, sda_o}, 0);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_DATA, 32'h69);
		go(cmd_single_write);
		chk(last_wr, 8'h69);
		$display("done: disable");
		summarize();
	end
endmodule : tb_i2cm_top
